/* logic/energy_pulse_output_gen.sv */
// digital-to-frequency output stage with creep threshold
`timescale 1ns/1ps
// What this block does
// - base rate from clock, binary division select
// - low-rate full scale ac rates, dc double
// - calibration rate at most 2048 times
// - calibration multiplier table by scale select
// - calibration from same power, shorter accumulation
// - low-rate outputs active low, alternating
// - low-rate pulse 275 ms, half-period offset
// - period under 550 ms gives half width
// - calibration pulse active high 90 ms
// - period under 180 ms gives half width
// - high-frequency mode pulse fixed 18 us
// - no pulses below no-load minimum rate
// - no-load minimum 0.0014 percent full scale
// - no-load threshold off in high-frequency mode
module energy_pulse_output_gen (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic signed [23:0] i_power_sample,
  input wire logic i_sample_valid,
  input wire logic i_rate_select_lo,
  input wire logic i_rate_select_hi,
  input wire logic i_calib_scale_select,
  output logic o_low_rate_pulse_a_n,
  output logic o_low_rate_pulse_b_n,
  output logic o_calibration_pulse_out
);
  localparam int AW = pulse_out_pkg::ACC_W;
  // --------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------
  logic [2:0] sel_meta;
  logic [2:0] sel_sync;
  always_ff @(posedge i_clk_sys)
  begin
    sel_meta <= {i_calib_scale_select, i_rate_select_hi, i_rate_select_lo};
    sel_sync <= sel_meta;
  end
  wire [1:0] rate_code = sel_sync[1:0];
  wire scale_hi = sel_sync[2];
  wire hf_mode = !scale_hi && rate_code == 2'h3;
  // --------------------------------------------------
  // base rate: master clock tick divider
  // --------------------------------------------------
  logic [6:0] mclk_cnt;
  wire mclk_tick = mclk_cnt == 7'(pulse_out_pkg::MCLK_DIV - 1);
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
      mclk_cnt <= 7'h0;
    else if (mclk_tick)
      mclk_cnt <= 7'h0;
    else
      mclk_cnt <= mclk_cnt + 7'h1;
  end
  // --------------------------------------------------
  // thresholds from rate selection
  // --------------------------------------------------
  // log2 of full-scale samples per low-rate pulse: faster code, lower
  function automatic logic [5:0] low_shift(input logic [1:0] code);
    low_shift = 6'(pulse_out_pkg::BASE_SHIFT + 2) - 6'(code);
  endfunction
  function automatic logic [3:0] cal_mul(input logic hi,
                                         input logic [1:0] code);
    cal_mul = hi ? pulse_out_pkg::MUL_HI_LOG2[code]
                 : pulse_out_pkg::MUL_LO_LOG2[code];
  endfunction
  wire [5:0] low_sh = low_shift(rate_code);
  wire [3:0] mul_sh = cal_mul(scale_hi, rate_code);
  wire [5:0] cal_sh = low_sh - {2'h0, mul_sh};
  wire [AW-1:0] low_thr = {{(AW-24){1'b0}}, 24'(pulse_out_pkg::FULL_SCALE)}
    << low_sh;
  wire [AW-1:0] cal_thr = {{(AW-24){1'b0}}, 24'(pulse_out_pkg::FULL_SCALE)}
    << cal_sh;
  // --------------------------------------------------
  // accumulators, one for the low-rate pair and one for calibration
  // --------------------------------------------------
  logic signed [AW-1:0] low_acc;
  logic signed [AW-1:0] cal_acc;
  wire signed [AW-1:0] sample_ext = AW'(i_power_sample);
  wire take = i_sample_valid && mclk_tick;
  wire low_fire_raw = take && (low_acc + sample_ext) >= $signed(low_thr);
  wire cal_fire_raw = take && (cal_acc + sample_ext) >= $signed(cal_thr);
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      low_acc <= '0;
      cal_acc <= '0;
    end
    else if (take)
    begin
      low_acc <= low_fire_raw ? low_acc + sample_ext - $signed(low_thr)
                              : low_acc + sample_ext;
      cal_acc <= cal_fire_raw ? cal_acc + sample_ext - $signed(cal_thr)
                              : cal_acc + sample_ext;
    end
  end
  // --------------------------------------------------
  // no-load threshold
  // --------------------------------------------------
  localparam logic [47:0] NL_NUM = 48'(pulse_out_pkg::FULL_SCALE)
    * 48'(pulse_out_pkg::NOLOAD_PPT);
  localparam logic [47:0] NL_LEVEL = NL_NUM
    / 48'(pulse_out_pkg::NOLOAD_DEN);
  wire below_min = i_power_sample < $signed(AW'(NL_LEVEL));
  wire allow = hf_mode || !below_min;
  wire low_fire = low_fire_raw && allow;
  wire cal_fire = cal_fire_raw && allow;
  // --------------------------------------------------
  // alternate low-rate pulses between two outputs
  // --------------------------------------------------
  logic which;
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
      which <= 1'b0;
    else if (low_fire)
      which <= !which;
  end
  // --------------------------------------------------
  // pulse shapers
  // --------------------------------------------------
  logic pa;
  logic pb;
  logic pc;
  pulse_shaper u_shape_a (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_fire(low_fire && !which),
    .i_width(32'(pulse_out_pkg::LOW_WIDTH_CYC)),
    .i_fixed(1'b0),
    .o_pulse(pa)
  );
  pulse_shaper u_shape_b (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_fire(low_fire && which),
    .i_width(32'(pulse_out_pkg::LOW_WIDTH_CYC)),
    .i_fixed(1'b0),
    .o_pulse(pb)
  );
  pulse_shaper u_shape_c (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_fire(cal_fire),
    .i_width(hf_mode ? 32'(pulse_out_pkg::HF_WIDTH_CYC)
                     : 32'(pulse_out_pkg::CAL_WIDTH_CYC)),
    .i_fixed(hf_mode),
    .o_pulse(pc)
  );
  // --------------------------------------------------
  // registered outputs
  // --------------------------------------------------
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      o_low_rate_pulse_a_n <= 1'b1;
      o_low_rate_pulse_b_n <= 1'b1;
      o_calibration_pulse_out <= 1'b0;
    end
    else
    begin
      o_low_rate_pulse_a_n <= !pa;
      o_low_rate_pulse_b_n <= !pb;
      o_calibration_pulse_out <= pc;
    end
  end
endmodule

/* shared/pulse_out_pkg.sv */
// constants for the energy pulse output stage
package pulse_out_pkg;
  // clock and time base
  localparam int CLK_HZ = 250_000_000;
  localparam int CLK_NS = 4;
  // nominal system clocks per master clock tick: divider for base rate
  localparam int MCLK_DIV = 70;
  // base rate divisor exponent; code 00 uses it plus 2 (2^23), lower for faster codes
  localparam int BASE_SHIFT = 21;
  // sample and accumulator widths
  localparam int SAMPLE_W = 24;
  localparam int ACC_W = 48;
  // pulse widths and period limits in ms
  localparam int LOW_WIDTH_MS = 275;
  localparam int LOW_PERIOD_MS = 550;
  localparam int CAL_WIDTH_MS = 90;
  localparam int CAL_PERIOD_MS = 180;
  // high frequency mode pulse width in ns
  localparam int HF_WIDTH_NS = 18_000;
  // cycle counts, derived at the system rate
  localparam int MS_CYC = 1_000_000 / CLK_NS;
  localparam int LOW_WIDTH_CYC = LOW_WIDTH_MS * MS_CYC;
  localparam int CAL_WIDTH_CYC = CAL_WIDTH_MS * MS_CYC;
  localparam int HF_WIDTH_CYC = (HF_WIDTH_NS + CLK_NS - 1) / CLK_NS;
  // cal multiplier per code, as log2: scale high / scale low
  localparam logic [3:0] MUL_HI_LOG2 [4] = '{4'h7, 4'h6, 4'h5, 4'h4};
  localparam logic [3:0] MUL_LO_LOG2 [4] = '{4'h6, 4'h5, 4'h4, 4'hB};
  // no-load threshold: 0.0014% of full scale, as parts per 10^7
  localparam int NOLOAD_PPT = 140;
  localparam int NOLOAD_DEN = 10_000_000;
  // full scale sample magnitude for the ac maximum
  localparam int FULL_SCALE = 24'h400000;
  // time counter width
  localparam int TCNT_W = 32;
endpackage

/* logic/pulse_shaper.sv */
// pulse shaper: fixed width or half-period when periods run short
`timescale 1ns/1ps
module pulse_shaper (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_fire,
  input wire logic [31:0] i_width,
  input wire logic i_fixed,
  output logic o_pulse
);
  logic [31:0] width_left;
  logic [31:0] since_last;
  logic [31:0] next_width;
  // half of the last period when it is short, else the fixed width
  assign next_width = (!i_fixed && since_last < {i_width[30:0], 1'b0})
    ? {1'b0, since_last[31:1]} : i_width;
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      width_left <= 32'h0;
      since_last <= 32'hFFFFFFFF;
      o_pulse <= 1'b0;
    end
    else if (i_fire)
    begin
      width_left <= next_width - 32'h1;
      since_last <= 32'h0;
      o_pulse <= 1'b1;
    end
    else
    begin
      if (since_last != 32'hFFFFFFFF)
        since_last <= since_last + 32'h1;
      if (width_left != 32'h0)
        width_left <= width_left - 32'h1;
      else
        o_pulse <= 1'b0;
    end
  end
endmodule

/* test/pulse_out_properties.sv */
// assertions on the ports of the energy pulse output stage
`timescale 1ns/1ps
module pulse_out_checker (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic signed [23:0] i_power_sample,
  input wire logic i_sample_valid,
  input wire logic i_rate_select_lo,
  input wire logic i_rate_select_hi,
  input wire logic i_calib_scale_select,
  input wire logic o_low_rate_pulse_a_n,
  input wire logic o_low_rate_pulse_b_n,
  input wire logic o_calibration_pulse_out
);
  localparam int NL = pulse_out_pkg::FULL_SCALE * pulse_out_pkg::NOLOAD_PPT
    / pulse_out_pkg::NOLOAD_DEN;
  logic [31:0] cal_len;
  logic [31:0] low_len;
  wire logic cal = o_calibration_pulse_out;
  wire logic low = !o_low_rate_pulse_a_n || !o_low_rate_pulse_b_n;
  wire logic hf = !i_calib_scale_select && i_rate_select_lo && i_rate_select_hi;
  always_ff @(posedge i_clk_sys)
  begin
    cal_len <= (i_nrst && cal) ? cal_len + 32'h1 : 32'h0;
    low_len <= (i_nrst && low) ? low_len + 32'h1 : 32'h0;
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  sequence s_held;
    cal [*8];
  endsequence
  sequence s_caused;
    $past(i_sample_valid, 2) && $past(i_power_sample, 2) > 0;
  endsequence
  property p_alt; o_low_rate_pulse_a_n || o_low_rate_pulse_b_n; endproperty
  property p_idle; $rose(i_nrst) |-> low == 1'b0 && !cal; endproperty
  property p_cause; $rose(cal) |-> s_caused; endproperty
  property p_minw; $rose(cal) |-> s_held; endproperty
  property p_hfw; $fell(cal) && hf |-> cal_len == pulse_out_pkg::HF_WIDTH_CYC;
  endproperty
  property p_calw; cal_len <= pulse_out_pkg::CAL_WIDTH_CYC; endproperty
  property p_loww; low_len <= pulse_out_pkg::LOW_WIDTH_CYC; endproperty
  property p_noload; $rose(cal) && !hf |-> $past(i_power_sample, 2) >= NL;
  endproperty
  a_alt: assert property (p_alt)
    else $error("both low-rate outputs low");
  a_idle: assert property (p_idle)
    else $error("outputs not idle after reset");
  a_cause: assert property (p_cause)
    else $error("calibration pulse without positive sample");
  a_minw: assert property (p_minw)
    else $error("calibration pulse too short");
  a_hfw: assert property (p_hfw)
    else $error("high-frequency pulse width wrong");
  a_calw: assert property (p_calw)
    else $error("calibration pulse too long");
  a_loww: assert property (p_loww)
    else $error("low-rate pulse too long");
  a_noload: assert property (p_noload)
    else $error("pulse from sample under no-load level");
endmodule
bind energy_pulse_output_gen pulse_out_checker u_chk (
  .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_power_sample(i_power_sample),
  .i_sample_valid(i_sample_valid), .i_rate_select_lo(i_rate_select_lo),
  .i_rate_select_hi(i_rate_select_hi),
  .i_calib_scale_select(i_calib_scale_select),
  .o_low_rate_pulse_a_n(o_low_rate_pulse_a_n),
  .o_low_rate_pulse_b_n(o_low_rate_pulse_b_n),
  .o_calibration_pulse_out(o_calibration_pulse_out));

/* test/pulse_counter_model.sv */
// counter input model: counts pulses, measures width, watches order
`timescale 1ns/1ps
module pulse_counter_model (
  input wire logic i_clk_sys,
  input wire logic i_low_a_n,
  input wire logic i_low_b_n,
  input wire logic i_cal,
  output int o_n_cal,
  output int o_n_low,
  output int o_cal_w,
  output int o_bad_order
);
  int run = 0;
  logic want_b = 1'b0;
  initial {o_n_cal, o_n_low, o_cal_w, o_bad_order} = '0;
  always @(posedge i_clk_sys)
  begin
    run <= i_cal ? run + 1 : 0;
    if (!i_cal && run != 0)
      o_cal_w <= run;
  end
  always @(posedge i_cal)
    o_n_cal++;
  always @(negedge i_low_a_n)
  begin
    o_bad_order += want_b;
    want_b = 1'b1;
    o_n_low++;
  end
  always @(negedge i_low_b_n)
  begin
    o_bad_order += !want_b;
    want_b = 1'b0;
    o_n_low++;
  end
endmodule

/* test/testbench.sv */
// self-checking bench for the energy pulse output stage
`timescale 1ns/1ps
module testbench;
  logic i_clk_sys = 1'b0;
  logic i_nrst = 1'b0;
  logic signed [23:0] smp = 24'h000000;
  logic vld = 1'b0;
  logic [1:0] code = 2'h0;
  logic scale = 1'b1;
  logic a_n, b_n, cal;
  int n_cal, n_low, cal_w, bad_order;
  int n_fail = 0;
  int compares = 0;
  logic [31:0] lf = 32'h000147D5;
  always #2 i_clk_sys = ~i_clk_sys;
  energy_pulse_output_gen dut (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
    .i_power_sample(smp), .i_sample_valid(vld), .i_rate_select_lo(code[0]),
    .i_rate_select_hi(code[1]), .i_calib_scale_select(scale),
    .o_low_rate_pulse_a_n(a_n), .o_low_rate_pulse_b_n(b_n),
    .o_calibration_pulse_out(cal));
  pulse_counter_model far (.i_clk_sys(i_clk_sys), .i_low_a_n(a_n),
    .i_low_b_n(b_n), .i_cal(cal), .o_n_cal(n_cal), .o_n_low(n_low),
    .o_cal_w(cal_w), .o_bad_order(bad_order));
  function automatic logic [31:0] next_lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int exp_width(input logic sc, input logic [1:0] c);
    return (!sc && c == 2'h3) ? 18000 / pulse_out_pkg::CLK_NS : 0;
  endfunction
  task automatic end_sim;
    if (n_fail == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_int(input int got, input int exp);
    compares++;
    if (got != exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic do_reset(input int n);
    i_nrst = 1'b0;
    repeat (n) @(posedge i_clk_sys);
    #1 i_nrst = 1'b1;
    @(posedge i_clk_sys);
    #1;
  endtask
  // mode 0 tiny, 1 negative, 2 large; mode 2 stops after one pulse
  task automatic run(input int mode, input int n);
    repeat (n)
    begin
      @(posedge i_clk_sys);
      #1 lf = next_lfsr(lf);
      vld = lf[0] | lf[1];
      smp = mode == 0 ? {19'h00000, lf[6:2]} :
        mode == 1 ? {1'b1, lf[22:0]} : {4'h7, lf[19:0]};
      if (mode == 2 && n_cal != 0 && cal === 1'b0)
        break;
    end
    repeat (2) @(posedge i_clk_sys);
    #1;
  endtask
  initial
  begin
    do_reset(16);
    chk_bit(a_n, 1'b1);
    chk_bit(b_n, 1'b1);
    chk_bit(cal, 1'b0);
    run(0, 3000);
    chk_int(n_cal, 0);
    scale = 1'b0;
    code = 2'h3;
    do_reset(4);
    chk_bit(cal, 1'b0);
    run(1, 3000);
    chk_int(n_cal, 0);
    run(2, 60000);
    chk_int(n_cal, 1);
    chk_int(cal_w, exp_width(scale, code));
    chk_int(n_low, 0);
    chk_int(bad_order, 0);
    end_sim;
  end
endmodule
